// [verilog/guard_pkg.sv]
package guard_pkg;

    localparam logic [7:0] OFF_GUARD_CTRL = 8'h00;
    localparam logic [7:0] OFF_CLK_CTRL = 8'h04;
    localparam logic [7:0] OFF_TMIN = 8'h08;
    localparam logic [7:0] OFF_TMAX = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    localparam int ACT_BIT = 7;
    localparam int LIVE_BIT = 6;
    localparam int TB_LSB = 2;
    localparam int IRQ_EN_BIT = 1;
    localparam logic [7:0] GUARD_RESET = 8'h7f;
    localparam logic [6:0] ROLL_VALUE = 7'h40;

    localparam int OSC_PER_STEP = 16384;
    localparam int WAKE_SHORT = 256;
    localparam int WAKE_LONG = 4096;
    localparam int MIN_BASE_ADD = 128;
    localparam int MIX_ADD = 192;
    localparam int PHASE_MULT = 64;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_HALT = 4'b0010,
        ST_WAKE = 4'b0100,
        ST_AHALT = 4'b1000
    } mode_t;

    function automatic logic [31:0] phase_hi(input logic [1:0] tb);
        case (tb)
            2'h0: phase_hi = 32'h4;
            2'h1: phase_hi = 32'h8;
            2'h2: phase_hi = 32'h14;
            default: phase_hi = 32'h31;
        endcase
    endfunction

    function automatic logic [31:0] phase_lo(input logic [1:0] tb);
        case (tb)
            2'h0: phase_lo = 32'h3b;
            2'h1: phase_lo = 32'h35;
            2'h2: phase_lo = 32'h23;
            default: phase_lo = 32'h36;
        endcase
    endfunction

    // Integer division floors, matching the timeout formula
    function automatic logic [31:0] timeout_f(input logic [1:0] tb,
                                              input logic [5:0] cnt,
                                              input logic is_max);
        logic [31:0] hi;
        logic [31:0] lo;
        logic [31:0] c;
        logic [31:0] q;
        logic [31:0] base;
        logic short_rng;
        hi = phase_hi(tb);
        lo = phase_lo(tb);
        c = {26'h0, cnt};
        q = (c * 32'h4) / hi;
        base = is_max ? 32'(OSC_PER_STEP)
                      : (lo + 32'(MIN_BASE_ADD)) * 32'(PHASE_MULT);
        short_rng = is_max ? (c <= hi / 32'h4) : (c < hi / 32'h4);
        if (short_rng) begin
            timeout_f = base + 32'(OSC_PER_STEP) * c;
        end else begin
            timeout_f = base + 32'(OSC_PER_STEP) * (c - q)
                      + (32'(MIX_ADD) + lo) * 32'(PHASE_MULT) * q;
        end
    endfunction

endpackage

// [verilog/guard_prescaler.sv]
`timescale 1ns/1ns
module guard_prescaler #(
    parameter int DIV = 16384
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic tick_d;

    // Never cleared by a reload, so timeouts vary by one step
    always_comb begin
        tick_d = (div_q == 16'(DIV - 1));
        div_d = tick_d ? 16'h0 : div_q + 16'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 16'h0;
            tick <= 1'b0;
        end else begin
            div_q <= div_d;
            tick <= tick_d;
        end
    end
endmodule

// [verilog/guard_timer.sv]
`timescale 1ns/1ns
// How it works
// - reload count is control bits 6..0
// - timebase selects high and low phase constants
// - minimum timeout from low constant, floored
// - maximum timeout from base 16384, floored
// - all timeout quotients truncate downward
// - plain halt steps once, then holds, no reset
// - external wake resumes after 256/4096 clocks
// - reset leaves activation clear unless hardware option
// - halt with halt-reset option makes reset unless interrupt enable set
// - active-halt freezes counter completely
// - active-halt wake resumes counting at once
// - reset resumes counting after 257/4097 clocks
// - hardware option forces watchdog always active
// - counter steps down every 16384 clocks in run state
// - active watchdog resets when 40h becomes 3Fh
// - activation bit sticks until reset
// - write with activation set, bit 6 clear resets
module guard_timer #(
    parameter int STEP_DIV = guard_pkg::OSC_PER_STEP
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_watchdog_opt,
    input wire logic halt_reset_option,
    input wire logic long_wake_sel,
    input wire logic halt_req,
    input wire logic ext_wake,
    input wire logic osc_wake,
    output logic wdg_reset
);
    logic tick;
    logic act_q;
    logic act_d;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [1:0] tb_q;
    logic [1:0] tb_d;
    logic irq_en_q;
    logic irq_en_d;
    guard_pkg::mode_t state_q;
    guard_pkg::mode_t state_d;
    logic step_q;
    logic step_d;
    logic pend_q;
    logic pend_d;
    logic [12:0] wait_q;
    logic [12:0] wait_d;
    logic rst_d;
    logic [31:0] rdata_d;
    logic [31:0] prdata_d;
    logic eff_act;
    logic setup;
    logic access;
    logic wr_guard;
    logic wr_clk;
    logic mapped;
    logic [12:0] wake_len;

    guard_prescaler #(
        .DIV(STEP_DIV)
    ) u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_guard = access && pwrite
                      && paddr == guard_pkg::OFF_GUARD_CTRL;
    assign wr_clk = access && pwrite && paddr == guard_pkg::OFF_CLK_CTRL;
    assign pready = 1'b1;
    assign eff_act = act_q || hw_watchdog_opt;
    assign wake_len = long_wake_sel ? 13'(guard_pkg::WAKE_LONG - 1)
                                    : 13'(guard_pkg::WAKE_SHORT - 1);

    always_comb begin
        case (paddr)
            guard_pkg::OFF_GUARD_CTRL,
            guard_pkg::OFF_CLK_CTRL,
            guard_pkg::OFF_TMIN,
            guard_pkg::OFF_TMAX,
            guard_pkg::OFF_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = access && !mapped;

    // Control, counter and halt sequencing
    always_comb begin
        act_d = act_q;
        cnt_d = cnt_q;
        tb_d = tb_q;
        irq_en_d = irq_en_q;
        state_d = state_q;
        step_d = step_q;
        pend_d = pend_q;
        wait_d = wait_q;
        rst_d = 1'b0;
        if (wr_clk) begin
            tb_d = pwdata[guard_pkg::TB_LSB +: 2];
            irq_en_d = pwdata[guard_pkg::IRQ_EN_BIT];
        end
        case (state_q)
            guard_pkg::ST_RUN: begin
                // Slow and wait modes do not reach this block
                if (tick) begin
                    cnt_d = cnt_q - 7'h1;
                    if (eff_act && cnt_q == guard_pkg::ROLL_VALUE) begin
                        rst_d = 1'b1;
                    end
                end
                if (halt_req) begin
                    if (irq_en_q) begin
                        state_d = guard_pkg::ST_AHALT;
                    end else if (halt_reset_option) begin
                        rst_d = 1'b1;
                    end else begin
                        state_d = guard_pkg::ST_HALT;
                        step_d = 1'b1;
                    end
                end
            end
            guard_pkg::ST_HALT: begin
                if (tick && step_q) begin
                    cnt_d = cnt_q - 7'h1;
                    step_d = 1'b0;
                end
                if (ext_wake) begin
                    state_d = guard_pkg::ST_WAKE;
                    wait_d = wake_len;
                    step_d = 1'b0;
                end
            end
            guard_pkg::ST_WAKE: begin
                if (pend_q) begin
                    wait_d = wake_len;
                    pend_d = 1'b0;
                end else if (wait_q == 13'h0) begin
                    state_d = guard_pkg::ST_RUN;
                end else begin
                    wait_d = wait_q - 13'h1;
                end
            end
            guard_pkg::ST_AHALT: begin
                if (osc_wake || ext_wake) begin
                    state_d = guard_pkg::ST_RUN;
                end
            end
            default: state_d = guard_pkg::ST_RUN;
        endcase
        // A reload wins over a same-cycle decrement
        if (wr_guard) begin
            act_d = act_q || pwdata[guard_pkg::ACT_BIT];
            cnt_d = pwdata[6:0];
            if ((pwdata[guard_pkg::ACT_BIT] || eff_act)
                && !pwdata[guard_pkg::LIVE_BIT]) begin
                rst_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= guard_pkg::GUARD_RESET[guard_pkg::ACT_BIT];
            cnt_q <= guard_pkg::GUARD_RESET[6:0];
            tb_q <= 2'h0;
            irq_en_q <= 1'b0;
            state_q <= guard_pkg::ST_WAKE;
            step_q <= 1'b0;
            pend_q <= 1'b1;
            wait_q <= 13'h0;
            wdg_reset <= 1'b0;
        end else begin
            act_q <= act_d;
            cnt_q <= cnt_d;
            tb_q <= tb_d;
            irq_en_q <= irq_en_d;
            state_q <= state_d;
            step_q <= step_d;
            pend_q <= pend_d;
            wait_q <= wait_d;
            wdg_reset <= rst_d;
        end
    end

    // Read data latched in setup, shown in the access cycle
    always_comb begin
        case (paddr)
            guard_pkg::OFF_GUARD_CTRL: rdata_d = {24'h0, act_q, cnt_q};
            guard_pkg::OFF_CLK_CTRL:
                rdata_d = {28'h0, tb_q, irq_en_q, 1'b0};
            guard_pkg::OFF_TMIN:
                rdata_d = guard_pkg::timeout_f(tb_q, cnt_q[5:0],
                                               1'b0);
            guard_pkg::OFF_TMAX:
                rdata_d = guard_pkg::timeout_f(tb_q, cnt_q[5:0],
                                               1'b1);
            guard_pkg::OFF_STATUS:
                rdata_d = {26'h0, eff_act, 1'b0, state_q};
            default: rdata_d = 32'h0;
        endcase
        prdata_d = (setup && !pwrite) ? rdata_d : prdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else begin
            prdata <= prdata_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence halt_exit_s;
        state_q == guard_pkg::ST_HALT && ext_wake;
    endsequence

    sequence wake_armed_s;
        state_q == guard_pkg::ST_WAKE && !pend_q && wait_q == wake_len;
    endsequence

    roll_reset_a: assert property (
        state_q == guard_pkg::ST_RUN && eff_act && tick && !wr_guard
        && cnt_q == 7'h40 |=> wdg_reset && cnt_q == 7'h3f)
        else $error("no reset on 40h to 3Fh roll");

    sw_reset_a: assert property (
        wr_guard && pwdata[7] && !pwdata[6] |=> wdg_reset)
        else $error("software reset missing");

    act_sticky_a: assert property (
        act_q |=> act_q)
        else $error("activation bit cleared");

    // Activation bit not checked here, so act_q may also fire it
    hw_force_a: assert property (
        hw_watchdog_opt && state_q == guard_pkg::ST_RUN && tick
        && cnt_q == guard_pkg::ROLL_VALUE && !wr_guard |=> wdg_reset)
        else $error("hardware option not forcing active");

    ahalt_freeze_a: assert property (
        state_q == guard_pkg::ST_AHALT && !wr_guard |=> $stable(cnt_q))
        else $error("counter moved in active halt");

    halt_reset_a: assert property (
        state_q == guard_pkg::ST_RUN && halt_req && !irq_en_q
        && halt_reset_option |=> wdg_reset
        && state_q == guard_pkg::ST_RUN)
        else $error("halt did not reset");

    quick_wake_a: assert property (
        state_q == guard_pkg::ST_AHALT && (osc_wake || ext_wake)
        |=> state_q == guard_pkg::ST_RUN)
        else $error("active halt wake delayed");

    wake_delay_a: assert property (
        halt_exit_s |=> wake_armed_s ##1
        (state_q == guard_pkg::ST_WAKE)[*8])
        else $error("halt wake delay too short");

    wake_hold_a: assert property (
        state_q == guard_pkg::ST_WAKE && (pend_q || wait_q != 13'h0)
        && !wr_guard |=> state_q == guard_pkg::ST_WAKE && $stable(cnt_q))
        else $error("counting resumed before delay");

    halt_quiet_a: assert property (
        state_q == guard_pkg::ST_HALT && !wr_guard |=> !wdg_reset)
        else $error("reset raised in halt");

    free_run_a: assert property (
        state_q == guard_pkg::ST_RUN && tick && !wr_guard
        |=> cnt_q == $past(cnt_q) - 7'h1)
        else $error("counter missed its step");

    halt_hold_a: assert property (
        state_q == guard_pkg::ST_HALT && !step_q && !wr_guard
        |=> $stable(cnt_q))
        else $error("counter moved after its halt step");

    wake_resume_a: assert property (
        state_q == guard_pkg::ST_WAKE && !pend_q && wait_q == 13'h0
        |=> state_q == guard_pkg::ST_RUN)
        else $error("counting did not resume after delay");

endmodule

// [bench/guard_timer_tb_top.sv]
`timescale 1ns/1ns
module guard_timer_tb_top;
    localparam int STEP = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hw_opt = 1'b0;
    logic halt_opt = 1'b0;
    logic long_wake = 1'b0;
    logic halt_req = 1'b0;
    logic ext_wake = 1'b0;
    logic osc_wake = 1'b0;
    logic wdg_reset;
    int miscompares = 0;
    int n_tests = 0;
    int rst_cnt = 0;
    int r0;
    int cyc = 0;
    int tb_v;
    int cn;
    logic [31:0] rd;
    logic err;
    logic [31:0] seed = 32'h74f2;
    logic [6:0] c0;

    guard_timer #(.STEP_DIV(STEP)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_watchdog_opt(hw_opt),
        .halt_reset_option(halt_opt), .long_wake_sel(long_wake),
        .halt_req(halt_req), .ext_wake(ext_wake), .osc_wake(osc_wake),
        .wdg_reset(wdg_reset));

    always #5 pclk = ~pclk;

    // Hang guard sized well above the whole sequence
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (wdg_reset === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cyc == 30000) begin
            miscompares++;
            summarize();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int hi_of(int tb);
        return tb == 0 ? 4 : tb == 1 ? 8 : tb == 2 ? 20 : 49;
    endfunction

    // Integer division floors, as the timeout formula demands
    function automatic int tmo(int tb, int c, bit mx);
        int hi;
        int lo;
        int q;
        int base;
        hi = hi_of(tb);
        lo = tb == 0 ? 59 : tb == 1 ? 53 : tb == 2 ? 35 : 54;
        q = 4 * c / hi;
        base = mx ? 16384 : (lo + 128) * 64;
        if (mx ? c <= hi / 4 : c < hi / 4) return base + 16384 * c;
        return base + 16384 * (c - q) + (192 + lo) * 64 * q;
    endfunction

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is tied high, so this wait ends after one clock
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (100) @(posedge pclk);
        apb(0, 8'h10, 0);
        check("state", {28'h0, rd[3:0]}, 32'h4);
        // Counter still held here, so the reset value is visible
        apb(0, 8'h00, 0);
        check("ctrl", rd, 32'h7f);
        repeat (200) @(posedge pclk);
    endtask

    // Polls the counter until a step has just happened
    task sync_tick();
        int n;
        apb(0, 8'h00, 0);
        c0 = rd[6:0];
        n = 0;
        do begin
            apb(0, 8'h00, 0);
            n++;
        end while (rd[6:0] === c0 && n < 20);
        c0 = rd[6:0];
    endtask

    task pulse_halt();
        @(posedge pclk) halt_req <= 1'b1;
        @(posedge pclk) halt_req <= 1'b0;
    endtask

    task summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        do_reset();
        apb(0, 8'h00, 0);
        check("act_off", {31'h0, rd[7]}, 32'h0);
        apb(0, 8'h04, 0);
        check("clk", rd, 32'h0);
        apb(0, 8'h14, 0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        sync_tick();
        repeat (45) @(posedge pclk);
        apb(0, 8'h00, 0);
        check("count", {25'h0, rd[6:0]}, {25'h0, c0 - 7'h3});
        r0 = rst_cnt;
        apb(1, 8'h00, 32'hc3);
        repeat (32) @(posedge pclk);
        check("early", rst_cnt, r0);
        repeat (40) @(posedge pclk);
        check("roll", rst_cnt, r0 + 1);
        do_reset();
        apb(0, 8'h00, 0);
        check("act_clr", {31'h0, rd[7]}, 32'h0);
        apb(1, 8'h00, 32'hff);
        apb(1, 8'h00, 32'h7f);
        apb(0, 8'h00, 0);
        check("sticky", {31'h0, rd[7]}, 32'h1);
        r0 = rst_cnt;
        apb(1, 8'h00, 32'h80);
        repeat (4) @(posedge pclk);
        check("soft", rst_cnt, r0 + 1);
        do_reset();
        sync_tick();
        apb(1, 8'h00, 32'h7f);
        c0 = 7'h7f;
        pulse_halt();
        apb(0, 8'h10, 0);
        check("state", {28'h0, rd[3:0]}, 32'h2);
        repeat (60) @(posedge pclk);
        apb(0, 8'h00, 0);
        check("halt_cnt", {25'h0, rd[6:0]}, {25'h0, c0 - 7'h1});
        @(posedge pclk) ext_wake <= 1'b1;
        @(posedge pclk) ext_wake <= 1'b0;
        repeat (200) @(posedge pclk);
        apb(0, 8'h10, 0);
        check("state", {28'h0, rd[3:0]}, 32'h4);
        repeat (100) @(posedge pclk);
        apb(0, 8'h10, 0);
        check("state", {28'h0, rd[3:0]}, 32'h1);
        apb(1, 8'h04, 32'h2);
        sync_tick();
        pulse_halt();
        apb(0, 8'h10, 0);
        check("state", {28'h0, rd[3:0]}, 32'h8);
        repeat (60) @(posedge pclk);
        apb(0, 8'h00, 0);
        check("frozen", {25'h0, rd[6:0]}, {25'h0, c0});
        // Counter frozen here, so the timeout reads cannot race a step
        for (int i = 0; i < 20; i++) begin
            tb_v = i % 4;
            cn = i < 4 ? 0 : i < 8 ? 63 : i < 12 ? hi_of(tb_v) / 4 :
                 int'(xs() % 64);
            apb(1, 8'h04, 32'(tb_v * 4 + 2));
            apb(1, 8'h00, 32'(64 + cn));
            apb(1, 8'h08, 32'h0);
            apb(0, 8'h08, 0);
            check("tmin", rd, 32'(tmo(tb_v, cn, 1'b0)));
            apb(0, 8'h0c, 0);
            check("tmax", rd, 32'(tmo(tb_v, cn, 1'b1)));
        end
        @(posedge pclk) osc_wake <= 1'b1;
        @(posedge pclk) osc_wake <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(0, 8'h10, 0);
        check("state", {28'h0, rd[3:0]}, 32'h1);
        apb(1, 8'h04, 32'h0);
        r0 = rst_cnt;
        halt_opt <= 1'b1;
        pulse_halt();
        repeat (4) @(posedge pclk);
        check("halt_rst", rst_cnt, r0 + 1);
        halt_opt <= 1'b0;
        do_reset();
        hw_opt <= 1'b1;
        apb(0, 8'h10, 0);
        check("hw_act", {31'h0, rd[5]}, 32'h1);
        r0 = rst_cnt;
        apb(1, 8'h00, 32'h41);
        repeat (40) @(posedge pclk);
        check("hw_roll", rst_cnt, r0 + 1);
        hw_opt <= 1'b0;
        long_wake <= 1'b1;
        do_reset();
        apb(0, 8'h10, 0);
        check("long_hold", {28'h0, rd[3:0]}, 32'h4);
        summarize();
    end
endmodule
